// ---- shared/synth2_postdiv_params.svh ----
// Purpose: Offsets, field positions, reset values and codes for the
//          synthesizer 2 post-divider channels A and B.
// Assumes: APB with 32-bit data; printed offsets are register indices.
// Notes:   Byte address of a register is four times its index.
// Operation
// R1 - Bits 23:20 choose frame, low-frequency or clock
// R2 - Not all ones: 50% clock, divide by 23:0
// R3 - Channel A, code 00: low-frequency clock, 15:0
// R4 - Channel A, other codes: frame pulse, sibling width
// R5 - Channel A codes: low, B, C, D
// R6 - Channel B, code 01: low-frequency clock, 15:0
// R7 - Channel B, other codes: frame pulse, sibling width
// R8 - Channel B codes: A, low, C, D
// R9 - Frame mode: 15:0 sibling periods between pulses
// R10 - Frame mode: bit 18 sets pulse polarity
// R11 - Frame mode: bit 19 picks middle or first-edge boundary
// R12 - Pulse lasts one sibling period, spacing start-to-start
`ifndef SYNTH2_POSTDIV_PARAMS_SVH
`define SYNTH2_POSTDIV_PARAMS_SVH

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define PD_ADDR_W 12
`define PD_IDX_CHAN_A 10'h098
`define PD_IDX_CHAN_B 10'h09b
`define PD_IDX_STATUS 10'h0b0
`define PD_CFG_RESET 24'h00_0000

// -----------------------------------------------------------------
// Field layout of a channel register
// -----------------------------------------------------------------
`define PD_FORM_HI 23
`define PD_FORM_LO 20
`define PD_FORM_SPECIAL 4'hf
`define PD_TYPE_BIT 19
`define PD_POL_BIT 18
`define PD_SRC_HI 17
`define PD_SRC_LO 16
`define PD_RATE_HI 15
`define PD_LOWF_CODE_A 2'h0
`define PD_LOWF_CODE_B 2'h1

`endif

// ---- shared/synth2_postdiv_pkg.sv ----
// Purpose: Types shared by the post-divider channel and its top.
// Assumes: Constants live in the params header.
// Notes:   Channel modes are one-hot.
package synth2_postdiv_pkg;

  // -----------------------------------------------------------------
  // Output form of one channel
  // -----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MODE_DIV = 3'b001,
    MODE_LOWF = 3'b010,
    MODE_FRAME = 3'b100
  } pd_mode_t;

endpackage : synth2_postdiv_pkg

// ---- logic/postdiv_channel.sv ----
// Purpose: One post-divider channel: divided clock, low-frequency
//          clock or frame pulse.
// Assumes: Tick inputs are one-cycle enables on core_clk; siblings
//          are levels made by logic on core_clk.
// Notes:   Ratios below two hold the clock output low.
`timescale 1ns/1ps
`include "synth2_postdiv_params.svh"

module postdiv_channel #(
  parameter logic [1:0] LOWF_CODE = 2'h0  // Source code meaning low clock
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [23:0] cfg,  // Channel configuration word
  input wire logic out_tick,  // Synthesizer output rate enable
  input wire logic base_tick,  // Synthesizer base rate enable
  input wire logic [3:0] sib,  // Sibling clocks indexed by code
  output logic clk_o,  // Channel output
  output synth2_postdiv_pkg::pd_mode_t mode_o  // Decoded form
);
  import synth2_postdiv_pkg::*;

  pd_mode_t mode;  // Decoded output form
  logic [23:0] ratio;  // Active divide ratio
  logic tick;  // Active count enable
  logic sib_sel;  // Chosen sibling level
  logic rise;  // Sibling rising edge
  logic fall;  // Sibling falling edge
  logic step;  // Frame timing edge
  logic [15:0] spacing;  // Periods between pulses
  logic [23:0] cnt_r, cnt_nxt;  // Divider phase
  logic sib_prev_r, sib_prev_nxt;  // Sibling level one cycle ago
  logic [15:0] gap_r, gap_nxt;  // Periods left to next pulse
  logic pulse_r, pulse_nxt;  // Pulse active, before polarity
  logic out_r, out_nxt;  // Output flop

  // -----------------------------------------------------------------
  // Form decode and sibling edges
  // -----------------------------------------------------------------
  always_comb
  begin
    if (cfg[`PD_FORM_HI:`PD_FORM_LO] != `PD_FORM_SPECIAL)
      mode = MODE_DIV;  // R1 R2
    else if (cfg[`PD_SRC_HI:`PD_SRC_LO] == LOWF_CODE)
      mode = MODE_LOWF;  // R3 R6
    else
      mode = MODE_FRAME;  // R4 R7
    // Low clock divides the base rate by the low 16 bits only
    ratio = (mode == MODE_LOWF) ? {8'h00, cfg[`PD_RATE_HI:0]} : cfg;
    tick = (mode == MODE_LOWF) ? base_tick : out_tick;
    spacing = cfg[`PD_RATE_HI:0];
    sib_sel = sib[cfg[`PD_SRC_HI:`PD_SRC_LO]];
    rise = sib_sel & ~sib_prev_r;
    fall = ~sib_sel & sib_prev_r;
    // First-edge style starts on rising edges; middle style starts
    // half a period early so the boundary sits mid-pulse
    step = cfg[`PD_TYPE_BIT] ? rise : fall;  // R11
  end

  // -----------------------------------------------------------------
  // Next state of counters, pulse and output
  // -----------------------------------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    sib_prev_nxt = sib_sel;
    gap_nxt = gap_r;
    pulse_nxt = pulse_r;
    out_nxt = 1'b0;
    // Wrap test uses >= so shrinking the ratio never strands the count
    if (ratio < 24'h00_0002)
      cnt_nxt = 24'h00_0000;
    else if (tick)
      cnt_nxt = (cnt_r >= ratio - 24'h00_0001) ? 24'h00_0000 : cnt_r + 24'h00_0001;  // R2 R3
    if (mode != MODE_FRAME)
    begin
      gap_nxt = 16'h0000;
      pulse_nxt = 1'b0;
    end
    else if (step)
    begin
      if (gap_r == 16'h0000)
      begin
        pulse_nxt = 1'b1;  // R4 R7 R12
        // Zero spacing behaves as one period
        gap_nxt = (spacing == 16'h0000) ? 16'h0000 : spacing - 16'h0001;  // R9
      end
      else
      begin
        pulse_nxt = 1'b0;  // R12
        gap_nxt = gap_r - 16'h0001;
      end
    end
    case (mode)
      MODE_DIV, MODE_LOWF:
        out_nxt = (ratio >= 24'h00_0002) && (cnt_r < (ratio >> 1));  // R2 R3 R6
      MODE_FRAME:
        out_nxt = pulse_r ^ cfg[`PD_POL_BIT];  // R10
      default:
        out_nxt = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // State registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 24'h00_0000;
      sib_prev_r <= 1'b0;
      gap_r <= 16'h0000;
      pulse_r <= 1'b0;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      sib_prev_r <= sib_prev_nxt;
      gap_r <= gap_nxt;
      pulse_r <= pulse_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_o = out_r;
  assign mode_o = mode;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence start_s;
    mode == MODE_FRAME && step && gap_r == 16'h0000;
  endsequence

  a_form_decode: assert property ((cfg[23:20] == 4'hf && cfg[17:16] != LOWF_CODE) |-> mode == MODE_FRAME) else $error("frame form not decoded");  // R1
  a_div_duty: assert property (mode == MODE_DIV && ratio >= 24'h00_0002 && cnt_r == 24'h00_0000 |=> out_r) else $error("divided clock not high at phase zero");  // R2
  a_lowf_hold: assert property (mode == MODE_LOWF && !base_tick && ratio >= 24'h00_0002 |=> $stable(cnt_r)) else $error("low clock advanced without base tick");  // R3 R6
  a_frame_start: assert property (start_s |=> pulse_r ##1 (out_r == (1'b1 ^ cfg[18]) || mode != MODE_FRAME)) else $error("frame pulse did not start");  // R4 R7
  a_frame_gap: assert property (start_s ##0 spacing > 16'h0001 |=> gap_r == $past(spacing) - 16'h0001) else $error("frame spacing not loaded");  // R9
  a_frame_pol: assert property (mode == MODE_FRAME ##1 mode == MODE_FRAME |-> out_r == ($past(pulse_r) ^ $past(cfg[18]))) else $error("frame polarity wrong");  // R10
  a_gci_edge: assert property (mode == MODE_FRAME && cfg[19] && !rise |=> $stable(pulse_r)) else $error("first-edge style moved off rising edge");  // R11
  a_pulse_end: assert property (mode == MODE_FRAME && pulse_r && step && gap_r != 16'h0000 |=> !pulse_r) else $error("pulse longer than one period");  // R12

endmodule : postdiv_channel

// ---- logic/synth2_post_divider_ab.sv ----
// Purpose: APB register slave and the two post-divider channels A
//          and B of synthesizer 2.
// Assumes: core_clk is the synthesizer 2 output domain; rate ticks
//          and sibling clocks C and D come from logic on core_clk.
// Notes:   One wait-free access phase: pready rises in the first
//          access cycle of every transfer.
`timescale 1ns/1ps
`include "synth2_postdiv_params.svh"

module synth2_post_divider_ab (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic synth_out_tick,  // Synthesizer output rate enable
  input wire logic synth_base_tick,  // Synthesizer base rate enable
  input wire logic sib_c_clk,  // Post-divider C level
  input wire logic sib_d_clk,  // Post-divider D level
  output logic clk_a_out,  // Channel A output
  output logic clk_b_out  // Channel B output
);
  import synth2_postdiv_pkg::*;

  // -----------------------------------------------------------------
  // Addresses
  // -----------------------------------------------------------------
  localparam logic [`PD_ADDR_W-1:0] ADDR_A = {`PD_IDX_CHAN_A, 2'b00};
  localparam logic [`PD_ADDR_W-1:0] ADDR_B = {`PD_IDX_CHAN_B, 2'b00};
  localparam logic [`PD_ADDR_W-1:0] ADDR_ST = {`PD_IDX_STATUS, 2'b00};

  logic [23:0] cfg_a_r, cfg_a_nxt;  // Channel A configuration
  logic [23:0] cfg_b_r, cfg_b_nxt;  // Channel B configuration
  logic [31:0] rdata_r, rdata_nxt;  // Read data, loaded in setup
  logic ready_r, ready_nxt;  // Answer flag
  logic err_r, err_nxt;  // Error flag: unmapped address or status write
  logic setup;  // Setup cycle of a transfer
  logic done;  // Completing edge of a transfer
  logic hit_a;  // Address decode: channel A
  logic hit_b;  // Address decode: channel B
  logic hit_st;  // Address decode: status
  logic [23:0] wmask;  // Byte lanes written
  logic [3:0] sib_a;  // Siblings seen by channel A
  logic [3:0] sib_b;  // Siblings seen by channel B
  logic out_a;  // Channel A output
  logic out_b;  // Channel B output
  pd_mode_t mode_a;  // Channel A form
  pd_mode_t mode_b;  // Channel B form

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  always_comb
  begin
    setup = psel & ~penable;
    done = psel & penable & ready_r;
    hit_a = (paddr == ADDR_A);
    hit_b = (paddr == ADDR_B);
    hit_st = (paddr == ADDR_ST);
    wmask = {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // -----------------------------------------------------------------
  // Register file next state
  // -----------------------------------------------------------------
  always_comb
  begin
    cfg_a_nxt = cfg_a_r;
    cfg_b_nxt = cfg_b_r;
    rdata_nxt = rdata_r;
    // Answer rises in the first access cycle, drops after completion
    ready_nxt = setup;
    // Error flag lives only in the access cycle, so it can drive
    // pslverr straight from its flop
    err_nxt = 1'b0;
    if (setup)
    begin
      // Unmapped addresses and writes to status answer with an error
      err_nxt = ~(hit_a | hit_b | (hit_st & ~pwrite));
      rdata_nxt = 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit_a)
          rdata_nxt = {8'h00, cfg_a_r};
        else if (hit_b)
          rdata_nxt = {8'h00, cfg_b_r};
        else if (hit_st)
          rdata_nxt = {24'h00_0000, mode_b, mode_a, out_b, out_a};
      end
    end
    // Writes land only on the completing edge
    if (done && pwrite && hit_a)
      cfg_a_nxt = (cfg_a_r & ~wmask) | (pwdata[23:0] & wmask);
    if (done && pwrite && hit_b)
      cfg_b_nxt = (cfg_b_r & ~wmask) | (pwdata[23:0] & wmask);
  end

  // -----------------------------------------------------------------
  // Register file flops
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_a_r <= `PD_CFG_RESET;
      cfg_b_r <= `PD_CFG_RESET;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      cfg_a_r <= cfg_a_nxt;
      cfg_b_r <= cfg_b_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = rdata_r;
  assign pready = ready_r;
  assign pslverr = err_r;

  // -----------------------------------------------------------------
  // Sibling routing; the low-clock slot is never selected in frame
  // form, so it is tied low
  // -----------------------------------------------------------------
  always_comb
  begin
    sib_a = {sib_d_clk, sib_c_clk, out_b, 1'b0};  // R5
    sib_b = {sib_d_clk, sib_c_clk, 1'b0, out_a};  // R8
  end

  // -----------------------------------------------------------------
  // Channels
  // -----------------------------------------------------------------
  postdiv_channel #(
    .LOWF_CODE(`PD_LOWF_CODE_A)
  ) u_chan_a (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(cfg_a_r),
    .out_tick(synth_out_tick),
    .base_tick(synth_base_tick),
    .sib(sib_a),
    .clk_o(out_a),
    .mode_o(mode_a)
  );

  postdiv_channel #(
    .LOWF_CODE(`PD_LOWF_CODE_B)
  ) u_chan_b (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(cfg_b_r),
    .out_tick(synth_out_tick),
    .base_tick(synth_base_tick),
    .sib(sib_b),
    .clk_o(out_b),
    .mode_o(mode_b)
  );

  assign clk_a_out = out_a;
  assign clk_b_out = out_b;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence write_a_s;
    psel && penable && pready && pwrite && paddr == ADDR_A && pstrb == 4'hf;
  endsequence

  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready) else $error("answer not one cycle after setup");
  a_apb_write: assert property (write_a_s |=> cfg_a_r == $past(pwdata[23:0])) else $error("channel A write lost");
  a_src_map_a: assert property (mode_a == MODE_FRAME && cfg_a_r[17:16] == 2'b01 |-> sib_a[1] == out_b) else $error("channel A source map wrong");  // R5
  a_src_map_b: assert property (mode_b == MODE_FRAME && cfg_b_r[17:16] == 2'b00 |-> sib_b[0] == out_a) else $error("channel B source map wrong");  // R8
  a_lowf_code_b: assert property (cfg_b_r[23:20] == 4'hf && cfg_b_r[17:16] == 2'b01 |-> mode_b == MODE_LOWF) else $error("channel B low clock code wrong");  // R6

endmodule : synth2_post_divider_ab

// ---- verif/synth_src_model.sv ----
// Purpose: Far-side sources: rate ticks and sibling clocks C and D.
// Assumes: Every level changes just after a core_clk rising edge.
// Notes:   Sibling clocks run free, as real post-dividers do.
`timescale 1ns/1ps
module synth_src_model #(
  parameter int OUT_DIV = 2,  // Cycles per output tick
  parameter int BASE_DIV = 8,  // Cycles per base tick
  parameter int C_HALF = 4,  // Half period of sibling C
  parameter int D_HALF = 6  // Half period of sibling D
)(
  input wire logic core_clk,
  input wire logic rst,
  output logic synth_out_tick,
  output logic synth_base_tick,
  output logic sib_c_clk,
  output logic sib_d_clk
);
  int cnt;  // Free-running cycle count
  // ---------------------------------------------------------------
  // Ticks and sibling levels
  // ---------------------------------------------------------------
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      synth_out_tick <= 1'b0;
      synth_base_tick <= 1'b0;
      sib_c_clk <= 1'b0;
      sib_d_clk <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      synth_out_tick <= (cnt % OUT_DIV) == 0;
      synth_base_tick <= (cnt % BASE_DIV) == 0;
      sib_c_clk <= ((cnt / C_HALF) % 2) == 1;
      sib_d_clk <= ((cnt / D_HALF) % 2) == 1;
    end
  end
endmodule : synth_src_model

// ---- verif/synth2_post_divider_ab_tb.sv ----
// Purpose: Self-checking bench for channels A and B.
// Assumes: Zero-wait APB slave; outputs sampled on falling edges.
// Notes:   Second measurement is used, so mode changes settle first.
`timescale 1ns/1ps
`include "synth2_postdiv_params.svh"
module synth2_post_divider_ab_tb;
  import synth2_postdiv_pkg::*;
  localparam int OUTP = 2;  // Cycles per output tick
  localparam int BASEP = 8;  // Cycles per base tick
  localparam int C_HALF = 4;
  localparam int D_HALF = 6;
  localparam logic [11:0] ADR_A = {`PD_IDX_CHAN_A, 2'b00};
  localparam logic [11:0] ADR_B = {`PD_IDX_CHAN_B, 2'b00};
  localparam logic [11:0] ADR_S = {`PD_IDX_STATUS, 2'b00};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic out_tick, base_tick, sib_c, sib_d, clk_a, clk_b, err;
  logic [23:0] shadow [2];  // Register model
  int num_errors = 0;
  int n_compared = 0;
  synth2_post_divider_ab DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .synth_out_tick(out_tick), .synth_base_tick(base_tick), .sib_c_clk(sib_c),
    .sib_d_clk(sib_d), .clk_a_out(clk_a), .clk_b_out(clk_b));
  synth_src_model #(.OUT_DIV(OUTP), .BASE_DIV(BASEP), .C_HALF(C_HALF),
    .D_HALF(D_HALF)) src (.core_clk(core_clk), .rst(rst),
    .synth_out_tick(out_tick), .synth_base_tick(base_tick),
    .sib_c_clk(sib_c), .sib_d_clk(sib_d));
  // ---------------------------------------------------------------
  // Clock and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    #(4 * 40000);
    num_errors++;
    wrap_up();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("compares %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // APB master: request held until pready is seen at an edge
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Values read here are those sampled at this rising edge
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50)
      num_errors++;
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Width at level lvl and full period, in cycles
  task automatic measure(input logic chb, input logic lvl, output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    @(negedge core_clk);
    while ((chb ? clk_b : clk_a) === lvl && n < 4000)
    begin
      @(negedge core_clk);
      n++;
    end
    while ((chb ? clk_b : clk_a) !== lvl && n < 4000)
    begin
      @(negedge core_clk);
      n++;
    end
    while ((chb ? clk_b : clk_a) === lvl && n < 4000)
    begin
      @(negedge core_clk);
      hi++;
      n++;
    end
    per = hi;
    while ((chb ? clk_b : clk_a) !== lvl && n < 4000)
    begin
      @(negedge core_clk);
      per++;
      n++;
    end
  endtask : measure
  function automatic logic [2:0] mode_of(input logic [23:0] c, input logic chb);
    if (c[23:20] != `PD_FORM_SPECIAL)
      return MODE_DIV;
    if (c[17:16] == {1'b0, chb})
      return MODE_LOWF;
    return MODE_FRAME;
  endfunction : mode_of
  // One configuration: program both, measure one, read status
  task automatic run_one(input logic [23:0] ca, input logic [23:0] cb, input logic chb);
    logic [23:0] c;
    logic lvl;
    int hi, per, ehi, eper, sibp;
    shadow[0] = ca;
    shadow[1] = cb;
    apb(1'b1, ADR_A, {8'h00, ca});
    apb(1'b1, ADR_B, {8'h00, cb});
    c = shadow[chb];
    lvl = 1'b1;
    if (mode_of(c, chb) == MODE_DIV)
    begin
      ehi = int'(c) / 2 * OUTP;
      eper = int'(c) * OUTP;
    end
    else if (mode_of(c, chb) == MODE_LOWF)
    begin
      ehi = int'(c[15:0]) / 2 * BASEP;
      eper = int'(c[15:0]) * BASEP;
    end
    else
    begin
      sibp = (c[17:16] == 2'd2) ? 2 * C_HALF : (c[17:16] == 2'd3) ? 2 * D_HALF :
        int'(shadow[~chb]) * OUTP;
      ehi = sibp;
      eper = int'(c[15:0]) * sibp;
      lvl = ~c[18];
    end
    measure(chb, lvl, hi, per);
    measure(chb, lvl, hi, per);
    check(32'(hi), 32'(ehi));
    check(32'(per), 32'(eper));
    apb(1'b0, ADR_S, 32'h0000_0000);
    check({26'h0, rd[7:2]}, {26'h0, mode_of(cb, 1'b1), mode_of(ca, 1'b0)});
  endtask : run_one
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h2360_6271));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, ADR_A, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0000);
    apb(1'b0, ADR_B, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    pwdata <= $urandom;
    @(posedge core_clk);
    apb(1'b1, ADR_B, pwdata);
    shadow[1] = pwdata[23:0];
    apb(1'b0, ADR_B, 32'h0000_0000);
    check(rd, {8'h00, shadow[1]});
    // Only byte lane 0 may land
    pstrb <= 4'h1;
    apb(1'b1, ADR_B, 32'h00ab_cdef);
    pstrb <= 4'hf;
    shadow[1][7:0] = 8'hef;
    apb(1'b0, ADR_B, 32'h0000_0000);
    check(rd, {8'h00, shadow[1]});
    apb(1'b0, 12'h000, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, ADR_S, 32'h0000_00ff);
    check({31'h0, err}, 32'h0000_0001);
    run_one(24'($urandom % 8 + 2), 24'h00_0003, 1'b0);
    run_one(24'h00_0005, 24'h00_0003, 1'b1);
    run_one(24'hf0_0004, 24'h00_0003, 1'b0);
    run_one(24'h00_0003, 24'hf1_0002, 1'b1);
    run_one(24'hf1_0004, 24'h00_0003, 1'b0);
    run_one(24'hf6_0003, 24'h00_0003, 1'b0);
    run_one(24'hfb_0002, 24'h00_0003, 1'b0);
    run_one(24'h00_0004, 24'hf0_0003, 1'b1);
    run_one(24'h00_0004, 24'hfe_0002, 1'b1);
    run_one(24'h00_0004, 24'hf3_0003, 1'b1);
    wrap_up();
  end
endmodule : synth2_post_divider_ab_tb
